// ===== rtl/chan_ctrl_pkg.sv
// Constants, offsets and carrier types for the channel sync and oscillator control bank
// Functional notes
// [R1] Coefficient window: 128 words of 20 bits
// [R2] Filter control bit 8 selects second bank
// [R3] One coefficient set feeds both I and Q
// [R4] Both banks together allow 256 taps
// [R5] Coefficient offset register selects active filter
// [R6] Sleep high powers down, low runs channel
// [R7] External sleep write updates all four channels
// [R8] Retune strobe loads and starts frequency countdown
// [R9] Frequency count at 1 loads active tuning word
// [R10] Start strobe loads and starts launch countdown
// [R11] Launch count at 1 clears sleep, runs
// [R12] Sync bit 1 retunes, bit 0 starts
// [R13] Any of four sync pins selectable
// [R14] Pin arming: start, retune, first-pulse-only bits
// [R15] Armed pin pulse acts like software sync
// [R16] Tuning word split halves; 16-bit phase offset
// [R17] Control bits 8-7 pin, 6 port
// [R18] Bits 5-4 choose input qualifier sample mode
// [R19] Bit 3 clears phase accumulator on retune
// [R20] Bit 2 amplitude dither, bit 1 phase
// [R21] Bypass routes port A to I, B to Q
// [R22] Retune count 1 immediate, 0 suppressed
// [R23] Launch count 1 immediate, 0 suppressed
// [R24] Counters step per sample; sync bits strobe
package chan_ctrl_pkg;

  localparam int NUM_CH    = 4;
  localparam int COEF_W    = 20;
  localparam int COEF_WORDS = 128;

  // Channel address map
  localparam logic [7:0] A_COEF_LAST   = 8'h7F;
  localparam logic [7:0] A_SLEEP       = 8'h80;
  localparam logic [7:0] A_SOFT_SYNC   = 8'h81;
  localparam logic [7:0] A_PIN_SYNC    = 8'h82;
  localparam logic [7:0] A_LAUNCH      = 8'h83;
  localparam logic [7:0] A_RETUNE      = 8'h84;
  localparam logic [7:0] A_TUNE_LO     = 8'h85;
  localparam logic [7:0] A_TUNE_HI     = 8'h86;
  localparam logic [7:0] A_PHASE       = 8'h87;
  localparam logic [7:0] A_OSC_CTRL    = 8'h88;
  localparam logic [7:0] A_COEF_OFFSET = 8'hA3;
  localparam logic [7:0] A_FIR_CTRL    = 8'hA4;
  localparam logic [2:0] EXT_A_SLEEP   = 3'h3;

  // Field positions
  localparam int SLEEP_BIT   = 0;
  localparam int SS_START    = 0;
  localparam int SS_RETUNE   = 1;
  localparam int PS_START_EN = 0;
  localparam int PS_RETUNE_EN = 1;
  localparam int PS_FIRST    = 2;
  localparam int OC_PIN_HI   = 8;
  localparam int OC_PIN_LO   = 7;
  localparam int OC_PORT_B   = 6;
  localparam int OC_MODE_HI  = 5;
  localparam int OC_MODE_LO  = 4;
  localparam int OC_CLR_PH   = 3;
  localparam int OC_AMP_DITH = 2;
  localparam int OC_PH_DITH  = 1;
  localparam int OC_BYPASS   = 0;
  localparam int FC_BANK     = 8;

  // Reset values
  localparam logic        SLEEP_RST = 1'b1;
  localparam logic [15:0] HALF_RST  = 16'h0000;
  localparam logic [8:0]  OSC_RST   = 9'h000;
  localparam logic [2:0]  PIN_RST   = 3'h0;
  localparam logic [19:0] DATA_ZERO = 20'h00000;

  typedef enum logic [1:0] {
    Q_MASK_LOW = 2'b00,
    Q_HIGH     = 2'b01,
    Q_RISE     = 2'b10,
    Q_FALL     = 2'b11
  } qual_mode_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  ch;
    logic [7:0]  addr;
    logic [19:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic        wr;
    logic [2:0]  addr;
    logic [7:0]  wdata;
  } ext_req_t;

endpackage : chan_ctrl_pkg

// ===== rtl/chan_ctrl.sv
// Per-channel control bank: coefficient RAM, sleep, sync hold-off and oscillator control
`timescale 1ns/1ps
module chan_ctrl
  import chan_ctrl_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Microprocessor port
  input  wire host_req_t             host_req,
  input  wire ext_req_t              ext_req,
  output logic [19:0]                rdata,
  output logic                       rvalid,
  // Sync pins and input qualifiers
  input  wire logic [3:0]            sync_pin,
  input  wire logic                  qual_a,
  input  wire logic                  qual_b,
  // Filter coefficient read, one word for both I and Q
  input  wire logic [NCH-1:0][7:0]   coef_tap,
  output logic [NCH-1:0][19:0]       coef_data,
  // Channel controls
  output logic [NCH-1:0]             sleep,
  output logic [NCH-1:0]             sample_en,
  output logic [NCH-1:0]             data_mask,
  output logic [NCH-1:0][31:0]       tuning_word,
  output logic [NCH-1:0][15:0]       phase_offset_word,
  output logic [NCH-1:0]             phase_clear,
  output logic [NCH-1:0]             port_b_sel,
  output logic [NCH-1:0]             amp_dither,
  output logic [NCH-1:0]             phase_dither,
  output logic [NCH-1:0]             bypass
);

  logic [COEF_W-1:0] coef_ram [NCH*2*COEF_WORDS];

  logic [NCH-1:0]        sleep_r;
  logic [NCH-1:0][2:0]   pin_arm_r;
  logic [NCH-1:0][15:0]  launch_r;
  logic [NCH-1:0][15:0]  retune_r;
  logic [NCH-1:0][15:0]  tune_lo_r;
  logic [NCH-1:0][15:0]  tune_hi_r;
  logic [NCH-1:0][15:0]  phase_r;
  logic [NCH-1:0][8:0]   osc_r;
  logic [NCH-1:0][7:0]   coef_off_r;
  logic [NCH-1:0][8:0]   fir_ctrl_r;
  logic [NCH-1:0][15:0]  launch_cnt_r;
  logic [NCH-1:0][15:0]  retune_cnt_r;
  logic [NCH-1:0][31:0]  tune_act_r;
  logic [NCH-1:0]        first_seen_r;
  logic [NCH-1:0]        launch_fire;
  logic [NCH-1:0]        retune_fire;
  logic [NCH-1:0]        pin_pulse;
  logic [3:0]            sync_d_r;
  logic                  qual_a_d_r;
  logic                  qual_b_d_r;
  logic [19:0]           rdata_nxt;

  // Inputs are synchronous, so one delay stage is enough for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_d_r   <= 4'h0;
      qual_a_d_r <= 1'b0;
      qual_b_d_r <= 1'b0;
    end else begin
      sync_d_r   <= sync_pin;
      qual_a_d_r <= qual_a;
      qual_b_d_r <= qual_b;
    end
  end

  // Coefficient store; the bank bit extends the 7-bit window address
  always_ff @(posedge clk) begin
    if (host_req.wr && host_req.addr <= A_COEF_LAST) begin
      coef_ram[{host_req.ch, fir_ctrl_r[host_req.ch][FC_BANK], host_req.addr[6:0]}] <=
        host_req.wdata;                                                            // [R1] [R2]
    end
  end

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic       hit_wr;
      logic       q_now;
      logic       q_old;
      logic       soft_start;
      logic       soft_retune;
      logic       start_trig;
      logic       retune_trig;
      logic [1:0] psel;
      logic [7:0] tap_addr;

      assign hit_wr      = host_req.wr && host_req.ch == 2'(g);
      assign soft_start  = hit_wr && host_req.addr == A_SOFT_SYNC
                           && host_req.wdata[SS_START];                              // [R12] [R24]
      assign soft_retune = hit_wr && host_req.addr == A_SOFT_SYNC
                           && host_req.wdata[SS_RETUNE];                             // [R12] [R24]
      assign psel        = osc_r[g][OC_PIN_HI:OC_PIN_LO];                            // [R17]
      assign pin_pulse[g] = sync_pin[psel] && !sync_d_r[psel]                        // [R13]
                            && !(pin_arm_r[g][PS_FIRST] && first_seen_r[g]);        // [R14]
      assign start_trig  = soft_start || (pin_pulse[g] && pin_arm_r[g][PS_START_EN]);  // [R15]
      assign retune_trig = soft_retune
                           || (pin_pulse[g] && pin_arm_r[g][PS_RETUNE_EN]);          // [R15]
      assign q_now = osc_r[g][OC_PORT_B] ? qual_b : qual_a;                          // [R17]
      assign q_old = osc_r[g][OC_PORT_B] ? qual_b_d_r : qual_a_d_r;

      // Sample clock enable from the qualifier mode
      always_comb begin
        case (qual_mode_t'(osc_r[g][OC_MODE_HI:OC_MODE_LO]))                         // [R18]
          Q_MASK_LOW: sample_en[g] = 1'b1;
          Q_HIGH:     sample_en[g] = q_now;
          Q_RISE:     sample_en[g] = q_now && !q_old;
          Q_FALL:     sample_en[g] = !q_now && q_old;
          default:    sample_en[g] = 1'b0;
        endcase
      end
      assign data_mask[g] = osc_r[g][OC_MODE_HI:OC_MODE_LO] == Q_MASK_LOW && !q_now; // [R18]

      // Launch countdown; value 1 fires at once, 0 never fires
      assign launch_fire[g] = (start_trig && launch_r[g] == 16'h0001)                // [R23]
                              || (!start_trig && sample_en[g]
                                  && launch_cnt_r[g] == 16'h0002);                   // [R11]
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          launch_cnt_r[g] <= HALF_RST;
        end else if (start_trig) begin
          launch_cnt_r[g] <= (launch_r[g] == 16'h0001) ? HALF_RST : launch_r[g];     // [R10]
        end else if (sample_en[g] && launch_cnt_r[g] >= 16'h0002) begin
          launch_cnt_r[g] <= (launch_cnt_r[g] == 16'h0002) ? HALF_RST
                                                           : launch_cnt_r[g] - 16'h0001; // [R24]
        end
      end

      // Retune countdown, same shape as launch
      assign retune_fire[g] = (retune_trig && retune_r[g] == 16'h0001)               // [R22]
                              || (!retune_trig && sample_en[g]
                                  && retune_cnt_r[g] == 16'h0002);                   // [R9]
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          retune_cnt_r[g] <= HALF_RST;
        end else if (retune_trig) begin
          retune_cnt_r[g] <= (retune_r[g] == 16'h0001) ? HALF_RST : retune_r[g];     // [R8]
        end else if (sample_en[g] && retune_cnt_r[g] >= 16'h0002) begin
          retune_cnt_r[g] <= (retune_cnt_r[g] == 16'h0002) ? HALF_RST
                                                           : retune_cnt_r[g] - 16'h0001; // [R24]
        end
      end

      // Sleep bit: hardware launch wins over a same-cycle host write
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sleep_r[g] <= SLEEP_RST;
        end else if (launch_fire[g]) begin
          sleep_r[g] <= 1'b0;                                                        // [R11]
        end else if (ext_req.wr && ext_req.addr == EXT_A_SLEEP) begin
          sleep_r[g] <= ext_req.wdata[g];                                            // [R7]
        end else if (hit_wr && host_req.addr == A_SLEEP) begin
          sleep_r[g] <= host_req.wdata[SLEEP_BIT];                                   // [R6]
        end
      end

      // First-pulse-only latch rearms when the arming register is rewritten
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          first_seen_r[g] <= 1'b0;
        end else if (pin_pulse[g]) begin
          first_seen_r[g] <= 1'b1;                                                   // [R14]
        end else if (hit_wr && host_req.addr == A_PIN_SYNC) begin
          first_seen_r[g] <= 1'b0;
        end
      end

      // Host-written configuration
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_arm_r[g]  <= PIN_RST;
          launch_r[g]   <= HALF_RST;
          retune_r[g]   <= HALF_RST;
          tune_lo_r[g]  <= HALF_RST;
          tune_hi_r[g]  <= HALF_RST;
          phase_r[g]    <= HALF_RST;
          osc_r[g]      <= OSC_RST;
          coef_off_r[g] <= 8'h00;
          fir_ctrl_r[g] <= 9'h000;
        end else if (hit_wr) begin
          case (host_req.addr)
            A_PIN_SYNC:    pin_arm_r[g]  <= host_req.wdata[2:0];                     // [R14]
            A_LAUNCH:      launch_r[g]   <= host_req.wdata[15:0];
            A_RETUNE:      retune_r[g]   <= host_req.wdata[15:0];
            A_TUNE_LO:     tune_lo_r[g]  <= host_req.wdata[15:0];                    // [R16]
            A_TUNE_HI:     tune_hi_r[g]  <= host_req.wdata[15:0];                    // [R16]
            A_PHASE:       phase_r[g]    <= host_req.wdata[15:0];                    // [R16]
            A_OSC_CTRL:    osc_r[g]      <= host_req.wdata[8:0];
            A_COEF_OFFSET: coef_off_r[g] <= host_req.wdata[7:0];                     // [R5]
            A_FIR_CTRL:    fir_ctrl_r[g] <= host_req.wdata[8:0];                     // [R2]
            default:       ;
          endcase
        end
      end

      // Active tuning word is shadowed; loaded on retune or on launch from sleep
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          tune_act_r[g]  <= {HALF_RST, HALF_RST};
          phase_clear[g] <= 1'b0;
        end else begin
          // A launch on a running channel only realigns timing, so it keeps the word
          if (retune_fire[g] || (launch_fire[g] && sleep_r[g])) begin
            tune_act_r[g] <= {tune_hi_r[g], tune_lo_r[g]};                           // [R9]
          end
          phase_clear[g] <= retune_fire[g] && osc_r[g][OC_CLR_PH];                   // [R19]
        end
      end

      // Filter read: offset picks which stored filter is active; one word serves I and Q
      assign tap_addr = coef_tap[g] + coef_off_r[g];                                 // [R5] [R4]
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          coef_data[g] <= DATA_ZERO;
        end else begin
          coef_data[g] <= coef_ram[{2'(g), tap_addr}];                               // [R3] [R4]
        end
      end

      assign sleep[g]             = sleep_r[g];                                      // [R6]
      assign tuning_word[g]       = tune_act_r[g];
      assign phase_offset_word[g] = phase_r[g];
      assign port_b_sel[g]        = osc_r[g][OC_PORT_B];                             // [R17]
      assign amp_dither[g]        = osc_r[g][OC_AMP_DITH];                           // [R20]
      assign phase_dither[g]      = osc_r[g][OC_PH_DITH];                            // [R20]
      assign bypass[g]            = osc_r[g][OC_BYPASS];                             // [R21]
    end
  endgenerate

  // Read mux; the sync strobe register and unmapped addresses read zero
  always_comb begin
    rdata_nxt = DATA_ZERO;
    if (host_req.addr <= A_COEF_LAST) begin
      rdata_nxt = coef_ram[{host_req.ch, fir_ctrl_r[host_req.ch][FC_BANK], host_req.addr[6:0]}];
    end else begin
      case (host_req.addr)
        A_SLEEP:       rdata_nxt = {19'h00000, sleep_r[host_req.ch]};
        A_PIN_SYNC:    rdata_nxt = {17'h00000, pin_arm_r[host_req.ch]};
        A_LAUNCH:      rdata_nxt = {4'h0, launch_r[host_req.ch]};
        A_RETUNE:      rdata_nxt = {4'h0, retune_r[host_req.ch]};
        A_TUNE_LO:     rdata_nxt = {4'h0, tune_lo_r[host_req.ch]};
        A_TUNE_HI:     rdata_nxt = {4'h0, tune_hi_r[host_req.ch]};
        A_PHASE:       rdata_nxt = {4'h0, phase_r[host_req.ch]};
        A_OSC_CTRL:    rdata_nxt = {11'h000, osc_r[host_req.ch]};
        A_COEF_OFFSET: rdata_nxt = {12'h000, coef_off_r[host_req.ch]};
        A_FIR_CTRL:    rdata_nxt = {11'h000, fir_ctrl_r[host_req.ch]};
        default:       rdata_nxt = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata  <= DATA_ZERO;
      rvalid <= 1'b0;
    end else begin
      rvalid <= host_req.rd;
      if (host_req.rd) begin
        rdata <= rdata_nxt;
      end
    end
  end

endmodule : chan_ctrl

// ===== verif/chan_ctrl_monitor.sv
// Port checker for the channel control bank
`timescale 1ns/1ps
module chan_ctrl_monitor
  import chan_ctrl_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Host port
  input  wire host_req_t      host_req,
  input  wire ext_req_t       ext_req,
  input  wire logic [19:0]    rdata,
  input  wire logic           rvalid,
  // Qualifiers and channel controls
  input  wire logic           qual_a,
  input  wire logic           qual_b,
  input  wire logic [NCH-1:0] sleep,
  input  wire logic [NCH-1:0] sample_en,
  input  wire logic [NCH-1:0] data_mask,
  input  wire logic [NCH-1:0] port_b_sel,
  input  wire logic [NCH-1:0] amp_dither,
  input  wire logic [NCH-1:0] phase_dither,
  input  wire logic [NCH-1:0] bypass
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rvalid_on_rd;
    host_req.rd |=> rvalid;
  endproperty
  a_rvalid_on_rd: assert property (p_rvalid_on_rd) else $error("read not answered");
  property p_rvalid_only;
    !host_req.rd |=> !rvalid;
  endproperty
  a_rvalid_only: assert property (p_rvalid_only) else $error("answer without read");
  property p_rdata_hold;
    !host_req.rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_ext_sleep;
    ext_req.wr && ext_req.addr == EXT_A_SLEEP |=> sleep == $past(ext_req.wdata[NCH-1:0]);
  endproperty
  a_ext_sleep: assert property (p_ext_sleep) else $error("shared sleep write lost");
  property p_osc_bits;
    host_req.wr && host_req.addr == A_OSC_CTRL && host_req.ch == 2'h0 |=>
      {port_b_sel[0], amp_dither[0], phase_dither[0], bypass[0]} ==
      {$past(host_req.wdata[6]), $past(host_req.wdata[2:0])};
  endproperty
  a_osc_bits: assert property (p_osc_bits) else $error("control bits wrong");
  property p_sleep_rise;
    !host_req.wr && !ext_req.wr |=> !$rose(sleep[0]);
  endproperty
  a_sleep_rise: assert property (p_sleep_rise) else $error("sleep set without write");
  property p_mask_en;
    data_mask[0] |-> sample_en[0];
  endproperty
  a_mask_en: assert property (p_mask_en) else $error("masked cycle not sampled");
  property p_mask_qual;
    data_mask[0] |-> !(port_b_sel[0] ? qual_b : qual_a);
  endproperty
  a_mask_qual: assert property (p_mask_qual) else $error("mask with qualifier high");
endmodule : chan_ctrl_monitor

bind chan_ctrl chan_ctrl_monitor #(.NCH(NCH)) i_mon (.clk, .rst, .host_req, .ext_req, .rdata,
  .rvalid, .qual_a, .qual_b, .sleep, .sample_en, .data_mask, .port_b_sel, .amp_dither,
  .phase_dither, .bypass);

// ===== verif/chan_ctrl_host.sv
// Host processor port and sync pulse source model
`timescale 1ns/1ps
module chan_ctrl_host
  import chan_ctrl_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Requests to the bank
  output host_req_t        host_req,
  output ext_req_t         ext_req,
  output logic [3:0]       sync_pin,
  // Read answer
  input  wire logic [19:0] rdata,
  input  wire logic        rvalid
);
  initial begin
    host_req = '0;
    ext_req  = '0;
    sync_pin = 4'h0;
  end
  task automatic wr(input logic [1:0] c, input logic [7:0] a, input logic [19:0] d);
    @(posedge clk);
    host_req <= '{wr: 1'b1, rd: 1'b0, ch: c, addr: a, wdata: d};
    @(posedge clk);
    host_req.wr    <= 1'b0;
    host_req.wdata <= ~d; // Released data scrambled so stale data cannot pass
  endtask : wr
  task automatic rd(input logic [1:0] c, input logic [7:0] a, output logic [19:0] d,
                    output logic ok);
    @(posedge clk);
    host_req <= '{wr: 1'b0, rd: 1'b1, ch: c, addr: a, wdata: host_req.wdata};
    @(posedge clk);
    host_req.rd <= 1'b0;
    ok = 1'b0;
    d  = 20'h00000;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      ok = rvalid;
      d  = rdata;
    end
  endtask : rd
  task automatic ext_wr(input logic [7:0] d);
    @(posedge clk);
    ext_req <= '{wr: 1'b1, addr: EXT_A_SLEEP, wdata: d};
    @(posedge clk);
    ext_req <= '{wr: 1'b0, addr: 3'h0, wdata: ~d};
  endtask : ext_wr
  task automatic pulse(input int p);
    @(posedge clk);
    sync_pin <= 4'(1 << p);
    @(posedge clk);
    sync_pin <= 4'h0;
  endtask : pulse
endmodule : chan_ctrl_host

// ===== verif/channel_sync_nco_control_tb.sv
// Self-checking testbench for the channel control bank
`timescale 1ns/1ps
module channel_sync_nco_control_tb
  import chan_ctrl_pkg::*;
;
  logic             clk, rst, rvalid, qual_a, qual_b, pc_seen;
  host_req_t        host_req;
  ext_req_t         ext_req;
  logic [19:0]      rdata;
  logic [3:0]       sync_pin, sleep, sample_en, data_mask, phase_clear;
  logic [3:0]       port_b_sel, amp_dither, phase_dither, bypass;
  logic [3:0][7:0]  coef_tap;
  logic [3:0][19:0] coef_data;
  logic [3:0][31:0] tuning_word;
  logic [3:0][15:0] phase_offset_word;
  int               n_mismatch, n_tests;
  chan_ctrl i_dut (.clk, .rst, .host_req, .ext_req, .rdata, .rvalid, .sync_pin, .qual_a, .qual_b,
    .coef_tap, .coef_data, .sleep, .sample_en, .data_mask, .tuning_word, .phase_offset_word,
    .phase_clear, .port_b_sel, .amp_dither, .phase_dither, .bypass);
  chan_ctrl_host i_host (.clk, .host_req, .ext_req, .sync_pin, .rdata, .rvalid);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Phase clear is a one-cycle pulse, so it is latched here rather than polled
  always_ff @(posedge clk) pc_seen <= rst ? 1'b0 : (pc_seen | phase_clear[0]);
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdchk(input logic [1:0] c, input logic [7:0] a, input logic [19:0] exp);
    logic [19:0] d;
    logic        ok;
    i_host.rd(c, a, d, ok);
    chk("read answered", 32'h1, 32'(ok));
    if (!ok) tally_and_finish();
    chk($sformatf("read %h", a), 32'(exp), 32'(d));
  endtask : rdchk
  // Counts edges until the awaited change shows; k equals the programmed hold-off count
  task automatic wait_k(input int g, input bit on_sleep, input logic [31:0] exp, input int k_exp);
    int k;
    k = 0;
    while ((on_sleep ? sleep[g] !== 1'b0 : tuning_word[g] !== exp) && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk("hold-off edges", 32'(k_exp), 32'(k));
    if (k == 40) tally_and_finish();
  endtask : wait_k
  task automatic t_regs;
    logic [7:0]  a [10] = '{A_SLEEP, A_PIN_SYNC, A_LAUNCH, A_RETUNE, A_TUNE_LO, A_TUNE_HI,
                            A_PHASE, A_OSC_CTRL, A_COEF_OFFSET, A_FIR_CTRL};
    logic [19:0] m [10] = '{20'h00001, 20'h00007, 20'h0FFFF, 20'h0FFFF, 20'h0FFFF, 20'h0FFFF,
                            20'h0FFFF, 20'h001FF, 20'h000FF, 20'h001FF};
    for (int i = 0; i < 10; i++) begin
      i_host.wr(2'h0, a[i], 20'hFFFFF);
      rdchk(2'h0, a[i], m[i]);
    end
    i_host.wr(2'h0, 8'h90, 20'hFFFFF);
    rdchk(2'h0, 8'h90, 20'h00000);
    rdchk(2'h0, A_SOFT_SYNC, 20'h00000);
    chk("shadowed word", 32'h0, tuning_word[0]);
    chk("phase offset", 32'hFFFF, 32'(phase_offset_word[0]));
    chk("ctrl bits", 32'hF, {port_b_sel[0], amp_dither[0], phase_dither[0], bypass[0]});
  endtask : t_regs
  task automatic t_coef;
    coef_tap[2] <= 8'h7F;
    i_host.wr(2'h2, 8'h7F, 20'h12345);
    i_host.wr(2'h2, A_FIR_CTRL, 20'h00100);
    i_host.wr(2'h2, 8'h7F, 20'hABCDE);
    rdchk(2'h2, 8'h7F, 20'hABCDE);
    i_host.wr(2'h2, A_FIR_CTRL, 20'h00000);
    rdchk(2'h2, 8'h7F, 20'h12345);
    chk("tap word", 32'h12345, 32'(coef_data[2]));
    i_host.wr(2'h2, A_COEF_OFFSET, 20'h00080);
    repeat (2) @(posedge clk);
    chk("offset tap word", 32'hABCDE, 32'(coef_data[2]));
  endtask : t_coef
  task automatic t_soft;
    i_host.wr(2'h0, A_LAUNCH, 20'h00001);
    i_host.wr(2'h0, A_TUNE_LO, 20'h05678);
    i_host.wr(2'h0, A_TUNE_HI, 20'h01234);
    i_host.wr(2'h0, A_OSC_CTRL, 20'h00008);
    i_host.wr(2'h0, A_SOFT_SYNC, 20'h00001);
    wait_k(0, 1'b1, 32'h0, 1);
    chk("start word", 32'h12345678, tuning_word[0]);
    i_host.wr(2'h0, A_TUNE_LO, 20'h00001);
    i_host.wr(2'h0, A_TUNE_HI, 20'h00000);
    i_host.wr(2'h0, A_RETUNE, 20'h00004);
    i_host.wr(2'h0, A_SOFT_SYNC, 20'h00002);
    wait_k(0, 1'b0, 32'h1, 4);
    repeat (2) @(posedge clk);
    chk("phase clear", 32'h1, 32'(pc_seen));
    i_host.wr(2'h0, A_TUNE_LO, 20'h00002);
    i_host.wr(2'h0, A_RETUNE, 20'h00000);
    i_host.wr(2'h0, A_SOFT_SYNC, 20'h00002);
    repeat (10) @(posedge clk);
    chk("suppressed retune", 32'h1, tuning_word[0]);
  endtask : t_soft
  task automatic t_pin;
    i_host.wr(2'h3, A_OSC_CTRL, 20'h00100);
    i_host.wr(2'h3, A_LAUNCH, 20'h00002);
    i_host.wr(2'h3, A_PIN_SYNC, 20'h00005);
    i_host.pulse(1);
    repeat (4) @(posedge clk);
    chk("other pin", 32'h1, 32'(sleep[3]));
    i_host.pulse(2);
    wait_k(3, 1'b1, 32'h0, 2);
    i_host.ext_wr(8'h0A);
    @(posedge clk);
    chk("shared sleep", 32'hA, 32'(sleep));
    i_host.pulse(2);
    repeat (6) @(posedge clk);
    chk("first pulse only", 32'h1, 32'(sleep[3]));
    i_host.wr(2'h3, A_TUNE_LO, 20'h00042);
    i_host.wr(2'h3, A_RETUNE, 20'h00001);
    i_host.wr(2'h3, A_PIN_SYNC, 20'h00002);
    i_host.pulse(2);
    wait_k(3, 1'b0, 32'h42, 1);
    chk("retune arm only", 32'h1, 32'(sleep[3]));
  endtask : t_pin
  task automatic t_qual;
    logic [4:0] q = 5'b01100;
    logic [4:0] en, mk;
    logic [4:0] e_en [5] = '{5'h1F, 5'h0C, 5'h04, 5'h10, 5'h0C};
    for (int m = 0; m < 5; m++) begin
      i_host.wr(2'h1, A_OSC_CTRL, (m == 4) ? 20'h00050 : 20'(m << 4));
      for (int i = 0; i <= 5; i++) begin
        @(posedge clk);
        if (i > 0) en[i-1] = sample_en[1];
        if (i > 0) mk[i-1] = data_mask[1];
        if (i < 5 && m < 4) qual_a <= q[i];
        if (i < 5 && m == 4) qual_b <= q[i];
      end
      chk($sformatf("sample mode %0d", m), 32'(e_en[m]), 32'(en));
      chk($sformatf("mask mode %0d", m), (m == 0) ? 32'h13 : 32'h0, 32'(mk));
    end
  endtask : t_qual
  initial begin
    rst      = 1'b1;
    qual_a   = 1'b0;
    qual_b   = 1'b0;
    coef_tap = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset sleep", 32'hF, 32'(sleep));
    t_regs();
    t_coef();
    t_soft();
    t_pin();
    t_qual();
    tally_and_finish();
  end
endmodule : channel_sync_nco_control_tb
